// file: rtl/mic_ctrl.sv
// measurement initiation controller top
`default_nettype none
`include "mic_map.svh"
module mic_ctrl #(
	parameter int AW = 4,
	parameter int DW = 16
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	input wire logic bus_trig,
	input wire logic listen_addr,
	input wire logic meas_done,
	output mic_pkg::mic_eng_cmd_s eng_cmd,
	output logic pending,
	output logic filt_en,
	output logic cont_en,
	output mic_pkg::mic_err_s err
);
	// ==================================================
	// command decode
	mic_pkg::mic_state_e state_ff;
	logic cont_ff;
	logic filt_ff;
	logic pend_ff;
	logic [1:0] trigdef_ff;
	logic [DW-1:0] err_code_ff;
	logic err_sticky_ff;
	mic_pkg::mic_eng_cmd_s eng_ff;
	mic_pkg::mic_err_s err_ff;
	logic [DW-1:0] rdata_ff;
	logic [7:0] q_cont;
	logic [7:0] q_filt;
	logic cmd_wr;
	logic do_init;
	logic do_abort;
	logic do_rst;
	logic do_on;
	logic do_off;
	logic trig_fire;

	assign cmd_wr = wr && addr == `MIC_ADDR_CMD;
	// bus trigger runs the defined action, only while listening
	assign trig_fire = bus_trig && listen_addr; // RULE1
	assign do_init = (cmd_wr && wdata[`MIC_CMD_INIT])
		|| (trig_fire && trigdef_ff == `MIC_TRIGDEF_INIT); // RULE1
	assign do_abort = (cmd_wr && wdata[`MIC_CMD_ABORT])
		|| (trig_fire && trigdef_ff == `MIC_TRIGDEF_ABORT); // RULE1
	assign do_rst = cmd_wr && wdata[`MIC_CMD_RST];
	assign do_on = (cmd_wr && wdata[`MIC_CMD_CONT_ON])
		|| (wr && addr == `MIC_ADDR_CTRL && wdata[`MIC_CTRL_CONT]);
	assign do_off = (cmd_wr && wdata[`MIC_CMD_CONT_OFF])
		|| (wr && addr == `MIC_ADDR_CTRL && !wdata[`MIC_CTRL_CONT]);

	// ==================================================
	// measurement sequencer
	mic_pkg::mic_state_e nxt_state;
	logic nxt_start;
	always_comb begin
		nxt_state = state_ff;
		nxt_start = 1'b0;
		case (state_ff)
			mic_pkg::mic_idle: begin
				// idle waits for a start request only
				if (do_rst) begin
					nxt_state = mic_pkg::mic_idle;
				end else if (do_on) begin
					nxt_state = mic_pkg::mic_cont; // RULE3
					nxt_start = 1'b1;
				end else if (do_init) begin
					nxt_state = mic_pkg::mic_single; // RULE11 RULE2
					nxt_start = 1'b1;
				end
			end
			mic_pkg::mic_single: begin // RULE13
				// on refused with error -213; off clears continuous and reports error -210; init ignored while busy
				if (do_abort || do_rst || meas_done) begin // RULE12
					nxt_state = mic_pkg::mic_idle;
				end
			end
			mic_pkg::mic_cont: begin
				if (do_rst || (do_off && (meas_done || do_abort))) begin
					nxt_state = mic_pkg::mic_idle; // RULE7
				end else if (meas_done || do_abort) begin
					if (cont_ff && !do_off) begin
						nxt_start = 1'b1; // RULE4 RULE8
					end else begin
						nxt_state = mic_pkg::mic_idle; // RULE7
					end
				end
			end
			default: nxt_state = mic_pkg::mic_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= mic_pkg::mic_cont;
		end else begin
			state_ff <= nxt_state; // RULE16
		end
	end

	// power-up: continuous on and one start issued
	logic boot_ff;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			boot_ff <= 1'b1;
		end else begin
			boot_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			eng_ff <= '0;
		end else begin
			eng_ff.start <= nxt_start || (boot_ff && !do_rst); // RULE16
			eng_ff.abort <= (do_abort || do_rst)
				&& state_ff != mic_pkg::mic_idle; // RULE8
		end
	end

	// ==================================================
	// continuous and filter settings
	logic busy_single;
	assign busy_single = state_ff == mic_pkg::mic_single;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cont_ff <= 1'b1; // RULE5
		end else if (do_rst) begin
			cont_ff <= 1'b0; // RULE5
		end else if (do_on && !busy_single) begin
			cont_ff <= 1'b1; // RULE9
		end else if (do_off) begin
			cont_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			filt_ff <= 1'b0;
		end else if (do_rst) begin
			filt_ff <= 1'b0; // RULE14
		end else if (wr && addr == `MIC_ADDR_CTRL) begin
			filt_ff <= wdata[`MIC_CTRL_FILT]; // RULE14
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			trigdef_ff <= `MIC_TRIGDEF_INIT;
		end else if (wr && addr == `MIC_ADDR_TRIGDEF) begin
			trigdef_ff <= wdata[1:0];
		end
	end

	// ==================================================
	// pending-operation flag
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_ff <= 1'b0;
		end else begin
			pend_ff <= nxt_state != mic_pkg::mic_idle; // RULE6 RULE7 RULE12
		end
	end

	// ==================================================
	// error reporting
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			err_ff <= '0;
		end else begin
			err_ff.valid <= busy_single && !do_rst && (do_on || do_off);
			if (busy_single && do_on) begin
				err_ff.code <= `MIC_ERR_INIT_IGNORED; // RULE9
			end else if (busy_single && do_off) begin
				err_ff.code <= `MIC_ERR_TRIGGER; // RULE10
			end
		end
	end

	// latest code readable; error set wins over read clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			err_code_ff <= '0;
			err_sticky_ff <= 1'b0;
		end else if (err_ff.valid) begin
			err_code_ff <= err_ff.code;
			err_sticky_ff <= 1'b1;
		end else if (rd && addr == `MIC_ADDR_ERR) begin
			err_code_ff <= '0;
			err_sticky_ff <= 1'b0;
		end
	end

	// ==================================================
	// register read port
	mic_ascii_bit u_qcont (
		.state(cont_ff),
		.ascii(q_cont)
	);
	mic_ascii_bit u_qfilt (
		.state(filt_ff),
		.ascii(q_filt)
	);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= '0;
		end else if (rd) begin
			case (addr)
				`MIC_ADDR_CTRL: rdata_ff <= {14'h0000, filt_ff, cont_ff};
				`MIC_ADDR_STAT: rdata_ff <= {12'h000, err_sticky_ff,
					state_ff == mic_pkg::mic_cont,
					state_ff == mic_pkg::mic_single, pend_ff};
				`MIC_ADDR_ERR: rdata_ff <= err_code_ff;
				`MIC_ADDR_QCONT: rdata_ff <= {8'h00, q_cont}; // RULE15
				`MIC_ADDR_QFILT: rdata_ff <= {8'h00, q_filt}; // RULE15
				`MIC_ADDR_TRIGDEF: rdata_ff <= {14'h0000, trigdef_ff};
				default: rdata_ff <= '0;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	assign rdata = rdata_ff;
	assign eng_cmd = eng_ff;
	assign pending = pend_ff;
	assign filt_en = filt_ff;
	assign cont_en = cont_ff;
	assign err = err_ff;

	// ==================================================
	// checks
	property p_rst_cont_off; // RULE5
		@(posedge ref_clk) disable iff (!arst_n)
		do_rst |=> !cont_ff;
	endproperty
	a_rst_cont_off: assert property (p_rst_cont_off) // RULE5
		else $error("reset command left continuous on");

	property p_on_starts; // RULE3
		@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_idle && do_on && !do_rst
		|=> eng_ff.start && pend_ff;
	endproperty
	a_on_starts: assert property (p_on_starts) // RULE3
		else $error("continuous on did not start");

	property p_cont_restart; // RULE4
		@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_cont && cont_ff && meas_done
		&& !do_off && !do_rst |=> eng_ff.start;
	endproperty
	a_cont_restart: assert property (p_cont_restart) // RULE4
		else $error("continuous did not restart");

	property p_no_start_idle; // RULE2
		@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_idle && !do_on && !do_init && !boot_ff
		|=> !eng_ff.start;
	endproperty
	a_no_start_idle: assert property (p_no_start_idle) // RULE2
		else $error("start without request");

	property p_err213; // RULE9
		@(posedge ref_clk) disable iff (!arst_n)
		busy_single && do_on && !do_rst
		|=> err_ff.valid && err_ff.code == `MIC_ERR_INIT_IGNORED
		&& cont_ff == $past(cont_ff);
	endproperty
	a_err213: assert property (p_err213) // RULE9
		else $error("error -213 missing");

	property p_err210; // RULE10
		@(posedge ref_clk) disable iff (!arst_n)
		busy_single && do_off && !do_on && !do_rst
		|=> err_ff.valid && err_ff.code == `MIC_ERR_TRIGGER;
	endproperty
	a_err210: assert property (p_err210) // RULE10
		else $error("error -210 missing");

	property p_single_done; // RULE12
		@(posedge ref_clk) disable iff (!arst_n)
		busy_single && (meas_done || do_abort) |=> !pend_ff;
	endproperty
	a_single_done: assert property (p_single_done) // RULE12
		else $error("pending not cleared");

	property p_one_active; // RULE16
		@(posedge ref_clk) disable iff (!arst_n)
		busy_single && do_init |=> !eng_ff.start;
	endproperty
	a_one_active: assert property (p_one_active) // RULE16
		else $error("second start while busy");

	property p_abort_keep; // RULE8
		@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_cont && do_abort && !do_off && !do_rst
		&& !do_on |=> cont_ff == $past(cont_ff) && eng_ff.abort;
	endproperty
	a_abort_keep: assert property (p_abort_keep) // RULE8
		else $error("abort changed continuous");

	property p_trig; // RULE1
		@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_idle && bus_trig && listen_addr
		&& trigdef_ff == `MIC_TRIGDEF_INIT && !cmd_wr && !wr
		|=> eng_ff.start ##1 busy_single;
	endproperty
	a_trig: assert property (p_trig) // RULE1
		else $error("bus trigger ignored");

	property p_overlap; // RULE13
		@(posedge ref_clk) disable iff (!arst_n)
		busy_single && wr && addr == `MIC_ADDR_CTRL
		|=> filt_ff == $past(wdata[`MIC_CTRL_FILT]);
	endproperty
	a_overlap: assert property (p_overlap) // RULE13
		else $error("setting refused while measuring");

	property p_rst_filt_off; // RULE14
		@(posedge ref_clk) disable iff (!arst_n)
		do_rst |=> !filt_ff;
	endproperty
	a_rst_filt_off: assert property (p_rst_filt_off) // RULE14
		else $error("reset command left filter on");

	property p_cont_last; // RULE7
		@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_cont && !cont_ff && meas_done
		&& !do_on && !do_rst |=> !pend_ff && !eng_ff.start;
	endproperty
	a_cont_last: assert property (p_cont_last) // RULE7
		else $error("pending kept after last measurement");

	c_single: cover property (@(posedge ref_clk) disable iff (!arst_n)
		busy_single ##[1:20] meas_done);
	c_err: cover property (@(posedge ref_clk) disable iff (!arst_n)
		err_ff.valid);
	c_cont_abort: cover property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_cont && do_abort);
	c_trig: cover property (@(posedge ref_clk) disable iff (!arst_n)
		trig_fire);
	c_cont_last: cover property (@(posedge ref_clk) disable iff (!arst_n)
		state_ff == mic_pkg::mic_cont && !cont_ff && meas_done);
endmodule
`default_nettype wire

// file: rtl/mic_map.svh
// constants for the measurement initiation controller
//
// Behaviour
// [RULE1] bus trigger while addressed to listen runs the action set by trigger definition
// [RULE2] continuous off: no measurement until continuous on or immediate initiate
// [RULE3] turning continuous on starts a new measurement at once
// [RULE4] continuous on: next measurement starts as soon as previous finishes
// [RULE5] power-up enables continuous; protocol reset leaves it disabled
// [RULE6] first measurement started by continuous on sets pending flag
// [RULE7] pending clears on abort or last measurement done after continuous off
// [RULE8] abort in continuous stops current measurement, keeps setting, restarts if on
// [RULE9] continuous on during single measurement: error -213, setting unchanged
// [RULE10] continuous off during single measurement: error -210
// [RULE11] immediate initiate starts one measurement or block per configuration
// [RULE12] immediate initiate sets pending; finish or abort clears it
// [RULE13] immediate initiate is overlapped; further commands still accepted
// [RULE14] channel one low-pass filter state settable, queryable, reset turns off
// [RULE15] state queries answer ASCII 0 for off or 1 for on
// [RULE16] at most one measurement active; start requests serialised against it
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH
`define MIC_ADDR_CTRL 4'h0
`define MIC_ADDR_CMD 4'h1
`define MIC_ADDR_STAT 4'h2
`define MIC_ADDR_ERR 4'h3
`define MIC_ADDR_QCONT 4'h4
`define MIC_ADDR_QFILT 4'h5
`define MIC_ADDR_TRIGDEF 4'h6
`define MIC_CTRL_CONT 0
`define MIC_CTRL_FILT 1
`define MIC_CMD_INIT 0
`define MIC_CMD_ABORT 1
`define MIC_CMD_RST 2
`define MIC_CMD_CONT_ON 3
`define MIC_CMD_CONT_OFF 4
`define MIC_ERR_INIT_IGNORED 16'hFF2B
`define MIC_ERR_TRIGGER 16'hFF2E
`define MIC_ASCII_ZERO 8'h30
`define MIC_ASCII_ONE 8'h31
`define MIC_TRIGDEF_NONE 2'h0
`define MIC_TRIGDEF_INIT 2'h1
`define MIC_TRIGDEF_ABORT 2'h2
`endif

// file: rtl/mic_pkg.sv
// types for the measurement initiation controller
`default_nettype none
package mic_pkg;
	typedef enum logic [1:0] {mic_idle, mic_single, mic_cont} mic_state_e;
	typedef struct packed {
		logic start;
		logic abort;
	} mic_eng_cmd_s;
	typedef struct packed {
		logic valid;
		logic [15:0] code;
	} mic_err_s;
endpackage
`default_nettype wire

// file: rtl/mic_ascii_bit.sv
// ascii 0/1 encoder for state queries
`default_nettype none
`include "mic_map.svh"
module mic_ascii_bit (
	input wire logic state,
	output logic [7:0] ascii
);
	assign ascii = state ? `MIC_ASCII_ONE : `MIC_ASCII_ZERO; // RULE15
endmodule
`default_nettype wire

// file: sim/mic_engine_model.sv
// behavioural measurement engine facing the initiation controller
`default_nettype none
module mic_engine_model (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [7:0] len,
	output logic meas_done,
	output logic [15:0] n_start
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_ff;
	logic [7:0] cnt_ff;
	// =====================================
	// one measurement at a time, len plus one cycles
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_ff <= 1'h0;
			cnt_ff <= 8'h00;
			meas_done <= 1'h0;
			n_start <= 16'h0000;
		end else begin
			meas_done <= 1'h0;
			if (start) begin
				busy_ff <= 1'h1;
				cnt_ff <= len;
				n_start <= n_start + 16'h0001;
			end else if (abort) begin
				busy_ff <= 1'h0;
			end else if (busy_ff && cnt_ff == 8'h00) begin
				// done only for a live run, never spontaneously
				busy_ff <= 1'h0;
				meas_done <= 1'h1;
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the measurement initiation controller
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, arst_n, wr, rd, bus_trig, listen_addr, meas_done;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, n_start, s;
	logic [7:0] len;
	logic pending, filt_en, cont_en;
	mic_pkg::mic_eng_cmd_s eng_cmd;
	mic_pkg::mic_err_s err;
	int miscompares = 0;
	int num_checks = 0;
	mic_ctrl DUT (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.bus_trig(bus_trig), .listen_addr(listen_addr),
		.meas_done(meas_done), .eng_cmd(eng_cmd), .pending(pending),
		.filt_en(filt_en), .cont_en(cont_en), .err(err));
	mic_engine_model eng (.ref_clk(ref_clk), .arst_n(arst_n),
		.start(eng_cmd.start), .abort(eng_cmd.abort), .len(len),
		.meas_done(meas_done), .n_start(n_start));
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	// =====================================
	// access tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wrr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge ref_clk);
		wr <= 1'h0;
	endtask
	task automatic rdr(input logic [3:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge ref_clk);
		rd <= 1'h0;
		@(negedge ref_clk);
		chk(rdata, exp);
	endtask
	task automatic trig(input logic lsn);
		@(posedge ref_clk);
		listen_addr <= lsn;
		bus_trig <= 1'h1;
		@(posedge ref_clk);
		bus_trig <= 1'h0;
		idle(3);
	endtask
	task automatic wait_idle;
		int i;
		for (i = 0; i < 300 && pending !== 1'h0; i++)
			@(negedge ref_clk);
		if (pending !== 1'h0) begin
			miscompares++;
			results();
		end
	endtask
	// =====================================
	// scenarios
	initial begin
		{arst_n, wr, rd, bus_trig, listen_addr} = 5'h00;
		addr = 4'h0;
		wdata = 16'h0000;
		len = 8'h0C;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'h1;
		idle(3);
		chk(16'(cont_en), 16'h0001);
		chk(16'(pending), 16'h0001);
		s = n_start;
		// one run takes len plus three cycles of turnaround
		idle(50);
		chk(16'(n_start > s + 16'h0002), 16'h0001);
		rdr(4'h4, 16'h0031);
		s = n_start;
		wrr(4'h1, 16'h0002);
		idle(4);
		chk(16'(cont_en), 16'h0001);
		chk(16'(n_start != s), 16'h0001);
		wrr(4'h0, 16'h0003);
		idle(2);
		chk(16'(filt_en), 16'h0001);
		rdr(4'h5, 16'h0031);
		wrr(4'h1, 16'h0004);
		wait_idle();
		chk(16'(cont_en), 16'h0000);
		chk(16'(filt_en), 16'h0000);
		rdr(4'h4, 16'h0030);
		rdr(4'h5, 16'h0030);
		s = n_start;
		idle(30);
		chk(n_start, s);
		len = 8'h20;
		wrr(4'h1, 16'h0001);
		idle(2);
		chk(16'(pending), 16'h0001);
		chk(n_start, s + 16'h0001);
		wrr(4'h1, 16'h0001);
		wrr(4'h1, 16'h0008);
		idle(1);
		chk(16'(err.valid), 16'h0001);
		chk(err.code, 16'hFF2B);
		rdr(4'h3, 16'hFF2B);
		chk(16'(cont_en), 16'h0000);
		wrr(4'h1, 16'h0010);
		rdr(4'h3, 16'hFF2E);
		chk(n_start, s + 16'h0001);
		chk(16'(pending), 16'h0001);
		wrr(4'h0, 16'h0002);
		idle(1);
		chk(16'(filt_en), 16'h0001);
		rdr(4'h2, 16'h000B);
		wait_idle();
		wrr(4'h1, 16'h0001);
		wrr(4'h1, 16'h0002);
		idle(1);
		chk(16'(eng_cmd.abort), 16'h0001);
		idle(1);
		chk(16'(pending), 16'h0000);
		s = n_start;
		trig(1'h0);
		chk(n_start, s);
		trig(1'h1);
		chk(n_start, s + 16'h0001);
		wait_idle();
		wrr(4'h6, 16'h0002);
		rdr(4'h6, 16'h0002);
		wrr(4'h1, 16'h0001);
		trig(1'h1);
		chk(16'(pending), 16'h0000);
		s = n_start;
		wrr(4'h0, 16'h0001);
		idle(2);
		chk(16'(pending), 16'h0001);
		chk(n_start, s + 16'h0001);
		wrr(4'h0, 16'h0000);
		wait_idle();
		s = n_start;
		idle(40);
		chk(n_start, s);
		rdr(4'hF, 16'h0000);
		results();
	end
endmodule
`default_nettype wire
